// >>> core/sld_top.sv
// sld_top: status led selection, power indicator and trigger input debounce
// with an avalon-mm register slave.
// assumes synchronous inputs, one 100 MHz clock and a 32-bit avalon master.
//
// How it works
// RQ1 - the power led follows the host cable power sense and is dark without it.
// RQ2 - after reset the green led shows usb 2.0 enumeration, and usb 3.0 enumeration may be chosen instead.
// RQ3 - each status led picks one source: register value, strobe, busy, streaming, trigger level or edge, blinks, or its line.
// RQ4 - the trigger input line appears on the green led only when selected there and on no other led.
// RQ5 - the trigger output line appears on the red led only when selected there.
// RQ6 - the trigger input has a rise, fall or both debounce filter in 10 us steps up to 81.92 ms.
// RQ7 - a filtered edge passes only after the raw level held for the full programmed time.
`timescale 1ns/1ps
module sld_top
   import sld_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // camera status and lines
   input wire logic vbus_present,
   input wire sld_cam_status_t cam_status,
   input wire logic trigger_input_line,
   input wire logic trigger_output_line,
   // debounced trigger towards the camera core
   output logic trigger_filtered,
   // leds
   output logic power_led,
   output logic green_status_led,
   output logic red_status_led
);

   logic [3:0] green_sel_reg;
   logic [3:0] red_sel_reg;
   logic green_val_reg;
   logic red_val_reg;
   sld_filter_cfg_t filter_reg;
   logic [31:0] rdata_reg;
   logic ack_reg;
   logic wait_reg;
   logic power_reg;
   logic green_reg;
   logic red_reg;
   logic filt_out_reg;
   logic [25:0] slow_cnt_reg;
   logic [23:0] fast_cnt_reg;
   logic slow_blink_reg;
   logic fast_blink_reg;
   logic filt_w;

   // one wait cycle per access; ack drops waitrequest for exactly one edge
   wire logic req = (avs_read || avs_write) && !ack_reg;
   // writes land at the edge where the master sees waitrequest low
   wire logic wr_go = avs_write && ack_reg;
   wire logic rd_go = avs_read && !ack_reg;
   wire logic wr_green = wr_go && (avs_address == OFS_GREEN_SEL) && avs_byteenable[0];
   wire logic wr_red = wr_go && (avs_address == OFS_RED_SEL) && avs_byteenable[0];
   wire logic wr_flt_lo = wr_go && (avs_address == OFS_FILTER) && avs_byteenable[0];
   wire logic wr_flt_hi1 = wr_go && (avs_address == OFS_FILTER) && avs_byteenable[1];
   wire logic wr_flt_hi2 = wr_go && (avs_address == OFS_FILTER) && avs_byteenable[2];

   // values beyond the maximum step count clamp to the longest time
   // 14 bits so that the longest time of 8192 steps is representable
   wire logic [13:0] steps_wr = {wr_flt_hi1 ? avs_writedata[13:8] : filter_reg.steps[13:8],
                                 wr_flt_lo ? avs_writedata[7:0] : filter_reg.steps[7:0]};
   wire logic [13:0] steps_next = (steps_wr > 14'(FILTER_MAX_STEPS)) ? 14'(FILTER_MAX_STEPS) : steps_wr; // RQ6

   function automatic logic [31:0] sel_word(input logic [3:0] sel, input logic val);
      sel_word = {23'h000000, val, 4'h0, sel};
   endfunction : sel_word

   wire logic [31:0] rd_mux =
      (avs_address == OFS_GREEN_SEL) ? sel_word(green_sel_reg, green_val_reg) :
      (avs_address == OFS_RED_SEL) ? sel_word(red_sel_reg, red_val_reg) :
      (avs_address == OFS_FILTER) ? {14'h0000, filter_reg.fall_en, filter_reg.rise_en, 2'h0, filter_reg.steps} :
      (avs_address == OFS_STATUS) ? {28'h0000000, trigger_input_line, red_reg, green_reg, filt_out_reg} :
      32'h00000000;

   // shared source decode; the line code picks a different line per led
   function automatic logic pick(input logic [3:0] sel, input logic val, input logic line,
                                 input sld_cam_status_t st, input logic slow, input logic fast,
                                 input logic allow_enum);
      unique case (sel)
         SRC_USB2_ENUM: pick = allow_enum ? st.usb2_enum : 1'b0; // RQ2
         SRC_USB3_ENUM: pick = allow_enum ? st.usb3_enum : 1'b0; // RQ2
         SRC_REG_VALUE: pick = val; // RQ3
         SRC_STROBE: pick = st.strobe; // RQ3
         SRC_BUSY: pick = st.busy; // RQ3
         SRC_STREAMING: pick = st.streaming; // RQ3
         SRC_TRIG_LEVEL: pick = st.trig_level; // RQ3
         SRC_TRIG_EDGE: pick = st.trig_edge; // RQ3
         SRC_SLOW_BLINK: pick = slow; // RQ3
         SRC_FAST_BLINK: pick = fast; // RQ3
         SRC_LINE: pick = line;
         default: pick = 1'b0;
      endcase
   endfunction : pick

   // green mirrors the input line, red the output line, never the reverse
   wire logic green_next = pick(green_sel_reg, green_val_reg, trigger_input_line, cam_status,
                                slow_blink_reg, fast_blink_reg, 1'b1); // RQ4
   wire logic red_next = pick(red_sel_reg, red_val_reg, trigger_output_line, cam_status,
                              slow_blink_reg, fast_blink_reg, 1'b0); // RQ5

   wire logic slow_wrap = slow_cnt_reg == 26'(SLOW_BLINK_CYC - 1);
   wire logic fast_wrap = fast_cnt_reg == 24'(FAST_BLINK_CYC - 1);

   sld_debounce u_debounce (
      .clk(clk),
      .rstn(rstn),
      .cfg(filter_reg),
      .raw_in(trigger_input_line),
      .filt_out(filt_w)
   );

   always_ff @(posedge clk) begin
      if (!rstn) begin
         green_sel_reg <= GREEN_SEL_RST; // RQ2
         red_sel_reg <= RED_SEL_RST;
         green_val_reg <= 1'b0;
         red_val_reg <= 1'b0;
         filter_reg <= '{rise_en: 1'b0, fall_en: 1'b0, steps: FILTER_TIME_RST};
      end else begin
         if (wr_green) begin
            green_sel_reg <= avs_writedata[3:0];
            green_val_reg <= avs_writedata[8];
         end
         if (wr_red) begin
            red_sel_reg <= avs_writedata[3:0];
            red_val_reg <= avs_writedata[8];
         end
         if (wr_flt_lo || wr_flt_hi1) begin
            filter_reg.steps <= steps_next; // RQ6
         end
         if (wr_flt_hi2) begin
            filter_reg.rise_en <= avs_writedata[FLT_RISE_BIT]; // RQ6
            filter_reg.fall_en <= avs_writedata[FLT_FALL_BIT]; // RQ6
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg <= req;
         wait_reg <= !req;
         rdata_reg <= rd_go ? rd_mux : rdata_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         slow_cnt_reg <= 26'h0000000;
         fast_cnt_reg <= 24'h000000;
         slow_blink_reg <= 1'b0;
         fast_blink_reg <= 1'b0;
      end else begin
         slow_cnt_reg <= slow_wrap ? 26'h0000000 : slow_cnt_reg + 26'h0000001;
         fast_cnt_reg <= fast_wrap ? 24'h000000 : fast_cnt_reg + 24'h000001;
         slow_blink_reg <= slow_wrap ? !slow_blink_reg : slow_blink_reg;
         fast_blink_reg <= fast_wrap ? !fast_blink_reg : fast_blink_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         power_reg <= 1'b0;
         green_reg <= 1'b0;
         red_reg <= 1'b0;
         filt_out_reg <= 1'b0;
      end else begin
         power_reg <= vbus_present; // RQ1
         green_reg <= green_next;
         red_reg <= red_next;
         filt_out_reg <= filt_w;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign power_led = power_reg;
   assign green_status_led = green_reg;
   assign red_status_led = red_reg;
   assign trigger_filtered = filt_out_reg;

   power_follows_a: assert property (@(posedge clk) disable iff (!rstn)
      ##1 power_led == $past(vbus_present)) // RQ1
      else $error("power led does not follow cable power");
   green_default_a: assert property (@(posedge clk)
      !rstn |=> green_sel_reg == 4'h0) // RQ2
      else $error("green led not on usb 2.0 enumeration after reset");
   green_input_a: assert property (@(posedge clk) disable iff (!rstn)
      (green_sel_reg == 4'ha) |=> green_status_led == $past(trigger_input_line)) // RQ4
      else $error("green led does not mirror trigger input");
   red_no_input_a: assert property (@(posedge clk) disable iff (!rstn)
      (red_sel_reg == 4'ha) |=> red_status_led == $past(trigger_output_line)) // RQ5
      else $error("red led does not mirror trigger output");
   red_reg_value_a: assert property (@(posedge clk) disable iff (!rstn)
      (red_sel_reg == 4'h2) |=> red_status_led == $past(red_val_reg)) // RQ3
      else $error("red led not showing register value");
   green_busy_a: assert property (@(posedge clk) disable iff (!rstn)
      (green_sel_reg == 4'h4) |=> green_status_led == $past(cam_status.busy)) // RQ3
      else $error("green led not showing busy");
   filter_limit_a: assert property (@(posedge clk) disable iff (!rstn)
      filter_reg.steps <= 14'(FILTER_MAX_STEPS)) // RQ6
      else $error("filter time above 81.92 ms");
   bus_answer_a: assert property (@(posedge clk) disable iff (!rstn)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered in one wait cycle");

endmodule : sld_top

// >>> core/sld_pkg.sv
// sld_pkg: register map, field layout, timing constants and carrier types
// for the status led and trigger input debounce block.
// assumes a 100 MHz system clock and a 32-bit avalon-mm register slave.
package sld_pkg;

   // clock and timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned FILTER_STEP_NS = 10_000;
   localparam int unsigned FILTER_STEP_CYC = FILTER_STEP_NS / (1_000_000_000 / CLK_HZ);
   localparam int unsigned FILTER_MAX_US = 81_920;
   localparam int unsigned FILTER_MAX_STEPS = FILTER_MAX_US * 1000 / FILTER_STEP_NS;
   localparam int unsigned SLOW_BLINK_MS = 500;
   localparam int unsigned FAST_BLINK_MS = 100;
   localparam int unsigned SLOW_BLINK_CYC = SLOW_BLINK_MS * (CLK_HZ / 1000);
   localparam int unsigned FAST_BLINK_CYC = FAST_BLINK_MS * (CLK_HZ / 1000);

   // register byte offsets
   localparam logic [3:0] OFS_GREEN_SEL = 4'h0;
   localparam logic [3:0] OFS_RED_SEL = 4'h4;
   localparam logic [3:0] OFS_FILTER = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;

   // filter register fields
   localparam int FLT_TIME_LSB = 0;
   localparam int FLT_TIME_W = 14;
   localparam int FLT_RISE_BIT = 16;
   localparam int FLT_FALL_BIT = 17;

   // status register fields
   localparam int ST_FILTERED_BIT = 0;
   localparam int ST_GREEN_BIT = 1;
   localparam int ST_RED_BIT = 2;
   localparam int ST_RAW_BIT = 3;

   // led source selection codes
   typedef enum logic [3:0] {
      SRC_USB2_ENUM = 4'h0,
      SRC_USB3_ENUM = 4'h1,
      SRC_REG_VALUE = 4'h2,
      SRC_STROBE = 4'h3,
      SRC_BUSY = 4'h4,
      SRC_STREAMING = 4'h5,
      SRC_TRIG_LEVEL = 4'h6,
      SRC_TRIG_EDGE = 4'h7,
      SRC_SLOW_BLINK = 4'h8,
      SRC_FAST_BLINK = 4'h9,
      SRC_LINE = 4'ha
   } sld_src_t;

   // reset values
   localparam logic [3:0] GREEN_SEL_RST = 4'h0;
   localparam logic [3:0] RED_SEL_RST = 4'h2;
   localparam logic [13:0] FILTER_TIME_RST = 14'h0000;

   // camera status sources bundled
   typedef struct packed {
      logic usb2_enum;
      logic usb3_enum;
      logic strobe;
      logic busy;
      logic streaming;
      logic trig_level;
      logic trig_edge;
   } sld_cam_status_t;

   // filter configuration
   typedef struct packed {
      logic rise_en;
      logic fall_en;
      logic [FLT_TIME_W-1:0] steps;
   } sld_filter_cfg_t;

endpackage : sld_pkg

// >>> core/sld_debounce.sv
// sld_debounce: edge-selective debounce filter on the trigger input.
// assumes the raw line is already synchronous to clk.
`timescale 1ns/1ps
module sld_debounce
   import sld_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // configuration and data
   input wire sld_filter_cfg_t cfg,
   input wire logic raw_in,
   output logic filt_out
);

   logic [13:0] step_cnt_reg;
   logic [13:0] step_cnt_next;
   logic [16:0] tick_cnt_reg;
   logic [16:0] tick_cnt_next;
   logic filt_reg;
   logic filt_next;

   // a filter time of zero, or an edge not selected, passes straight through
   wire logic differs = raw_in != filt_reg;
   wire logic filtered_dir = raw_in ? cfg.rise_en : cfg.fall_en;
   wire logic bypass = !filtered_dir || (cfg.steps == 14'h0000);
   wire logic tick = tick_cnt_reg == 17'(FILTER_STEP_CYC - 1);
   wire logic held_long = tick && (step_cnt_reg == cfg.steps - 14'h0001);

   // any return to the old level restarts the count, so short pulses vanish
   assign tick_cnt_next = (!differs || bypass || tick) ? 17'h00000 : tick_cnt_reg + 17'h00001; // RQ7
   assign step_cnt_next = (!differs || bypass) ? 14'h0000 : (tick ? step_cnt_reg + 14'h0001 : step_cnt_reg); // RQ7
   assign filt_next = (differs && (bypass || held_long)) ? raw_in : filt_reg; // RQ6

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tick_cnt_reg <= 17'h00000;
         step_cnt_reg <= 14'h0000;
         filt_reg <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         step_cnt_reg <= step_cnt_next;
         filt_reg <= filt_next;
      end
   end

   assign filt_out = filt_reg;

   // a filtered change needs the raw level to stand the whole programmed time
   sequence raw_changed_s;
      !bypass && differs && !held_long;
   endsequence
   short_pulse_blocked_a: assert property (@(posedge clk) disable iff (!rstn)
      raw_changed_s |=> filt_reg == $past(filt_reg)) // RQ7
      else $error("filtered output changed before filter time");
   bypass_pass_a: assert property (@(posedge clk) disable iff (!rstn)
      (bypass && differs) |=> filt_reg == $past(raw_in)) // RQ6
      else $error("unfiltered edge not passed in one cycle");
   step_width_a: assert property (@(posedge clk) disable iff (!rstn)
      tick_cnt_reg < 17'(FILTER_STEP_CYC)) // RQ6
      else $error("step counter past one 10us step");

endmodule : sld_debounce

// >>> testbench/sld_far_side.sv
// sld_far_side: external trigger source driving the raw trigger input.
// assumes hold() is called right after a rising clock edge.
`timescale 1ns/1ps
module sld_far_side (
   // clock
   input wire logic clk,
   // trigger line towards the camera
   output logic trig
);
   initial trig = 1'h0;
   // level kept for whole cycles so pulse widths are exact
   task hold(input logic lvl, input int cyc);
      trig <= lvl;
      repeat (cyc) @(posedge clk);
   endtask : hold
endmodule : sld_far_side

// >>> testbench/testbench.sv
// testbench: power led, led source selection, registers and trigger debounce.
// assumes sld_top, the sld_pkg constants and a 100 MHz clock.
`timescale 1ns/1ps
module testbench;
   import sld_pkg::*;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic vbus_present = 1'h0;
   sld_cam_status_t cam_status = '0;
   logic trigger_input_line;
   logic trigger_output_line = 1'h0;
   logic trigger_filtered;
   logic power_led;
   logic green_status_led;
   logic red_status_led;
   int n_fail = 0;
   int checks_done = 0;
   int n;
   logic v;
   logic [31:0] rd;
   logic [31:0] w;
   always #5 clk = ~clk;
   sld_top sld_top_inst (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vbus_present(vbus_present),
      .cam_status(cam_status), .trigger_input_line(trigger_input_line),
      .trigger_output_line(trigger_output_line), .trigger_filtered(trigger_filtered),
      .power_led(power_led), .green_status_led(green_status_led), .red_status_led(red_status_led));
   sld_far_side sld_far_side_inst (.clk(clk), .trig(trigger_input_line));
   task chk_bit(input logic exp, input logic got, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_bit
   task chk_word(input logic [31:0] exp, input logic [31:0] got, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word
   // one bus cycle; the extra edge at the end keeps back-to-back calls apart
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge clk);
   endtask : bus
   task edge_time(input logic from, output int c);
      c = 0;
      while (trigger_filtered === from && c < 9000) begin
         @(posedge clk);
         c++;
      end
   endtask : edge_time
   function automatic logic exp_led(input logic [3:0] c, input sld_cam_status_t s, input logic val,
      input logic line, input logic red);
      case (c)
         4'h0: return red ? 1'h0 : s.usb2_enum;
         4'h1: return red ? 1'h0 : s.usb3_enum;
         4'h2: return val;
         4'h3: return s.strobe;
         4'h4: return s.busy;
         4'h5: return s.streaming;
         4'h6: return s.trig_level;
         4'h7: return s.trig_edge;
         // the run ends long before the first blink toggle, so blinks read dark
         4'h8: return 1'h0;
         4'h9: return 1'h0;
         4'ha: return line;
         default: return 1'h0;
      endcase
   endfunction : exp_led
   task wrap_up;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'hac44));
      repeat (16) @(posedge clk);
      rstn <= 1'h1;
      @(posedge clk);
      chk_bit(1'h0, green_status_led, "green after reset");
      chk_bit(1'h0, red_status_led, "red after reset");
      bus(1'h0, OFS_GREEN_SEL, 32'h0);
      chk_word(32'h0, rd, "green select reset");
      bus(1'h0, OFS_RED_SEL, 32'h0);
      chk_word(32'h2, rd, "red select reset");
      bus(1'h0, OFS_FILTER, 32'h0);
      chk_word(32'h0, rd, "filter reset");
      bus(1'h1, OFS_FILTER, 32'h0000_3fff);
      bus(1'h0, OFS_FILTER, 32'h0);
      chk_word(32'(FILTER_MAX_STEPS), rd, "filter clamp");
      bus(1'h0, 4'h6, 32'h0);
      chk_word(32'h0, rd, "unmapped read");
      $display("test reset done");
      repeat (8) begin
         vbus_present <= 1'($urandom);
         repeat (2) @(posedge clk);
         chk_bit(vbus_present, power_led, "power led");
      end
      $display("test power done");
      for (int c = 0; c <= 10; c++) begin
         repeat (3) begin
            v = 1'($urandom);
            w = {23'h0, v, 4'h0, 4'(c)};
            bus(1'h1, OFS_GREEN_SEL, w);
            bus(1'h0, OFS_GREEN_SEL, 32'h0);
            chk_word(w, rd & 32'h10f, "green select readback");
            bus(1'h1, OFS_RED_SEL, w);
            cam_status <= sld_cam_status_t'($urandom);
            trigger_output_line <= 1'($urandom);
            sld_far_side_inst.hold(1'($urandom), 6);
            chk_bit(exp_led(4'(c), cam_status, v, trigger_input_line, 1'h0), green_status_led, "green");
            chk_bit(exp_led(4'(c), cam_status, v, trigger_output_line, 1'h1), red_status_led, "red");
         end
      end
      trigger_output_line <= 1'h0;
      sld_far_side_inst.hold(1'h1, 6);
      chk_bit(1'h0, red_status_led, "red ignores input");
      $display("test leds done");
      sld_far_side_inst.hold(1'h0, 6);
      bus(1'h1, OFS_FILTER, 32'h0001_0002);
      sld_far_side_inst.hold(1'h1, 1990);
      sld_far_side_inst.hold(1'h0, 10);
      chk_bit(1'h0, trigger_filtered, "short rise dropped");
      sld_far_side_inst.hold(1'h1, 0);
      edge_time(1'h0, n);
      chk_bit(1'h1, n >= 2000 && n <= 2004, "rise after 20 us");
      sld_far_side_inst.hold(1'h0, 0);
      edge_time(1'h1, n);
      chk_bit(1'h1, n <= 4, "unfiltered fall");
      bus(1'h1, OFS_FILTER, 32'h0002_0001);
      sld_far_side_inst.hold(1'h1, 0);
      edge_time(1'h0, n);
      chk_bit(1'h1, n <= 4, "unfiltered rise");
      sld_far_side_inst.hold(1'h0, 990);
      sld_far_side_inst.hold(1'h1, 50);
      chk_bit(1'h1, trigger_filtered, "short fall dropped");
      sld_far_side_inst.hold(1'h0, 0);
      edge_time(1'h1, n);
      chk_bit(1'h1, n >= 1000 && n <= 1004, "fall after 10 us");
      bus(1'h0, OFS_STATUS, 32'h0);
      chk_bit(1'h0, rd[ST_FILTERED_BIT], "status filtered");
      bus(1'h1, OFS_FILTER, 32'h0003_0000);
      sld_far_side_inst.hold(1'h1, 0);
      edge_time(1'h0, n);
      chk_bit(1'h1, n <= 4, "zero time passes");
      $display("test debounce done");
      wrap_up();
   end
endmodule : testbench
